// ### logic/isx_pkg.sv
// Shared constants and types of the two-wire slave transmitter and 10-bit receiver
package isx_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Widths and counts
  localparam int             BYTE_W        = 8;
  localparam int             CFG_W         = 5;
  localparam int             LINK_SYNC_W   = 4;
  localparam logic [3:0]     CNT_ZERO      = 4'h0;
  localparam logic [3:0]     CNT_ONE       = 4'h1;
  localparam logic [3:0]     CNT_START     = 4'h2;
  localparam logic [3:0]     CNT_EIGHTH    = 4'h7;
  localparam logic [3:0]     CNT_NINTH     = 4'h8;

  ////////////////////////////////////////////////////////////////////////////////
  // Address compare layout
  localparam logic [4:0]     TEN_HIGH_MARK = 5'h1e;
  localparam int             TEN_MARK_LSB  = 3;
  localparam int             TEN_HI_MSB    = 2;
  localparam int             TEN_HI_LSB    = 1;
  localparam int             ADDR_RW_BIT   = 0;
  localparam int             TX_MSB        = 7;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0]     BYTE_RESET    = 8'h00;
  localparam logic [7:0]     ADDR_RESET    = 8'h00;
  localparam logic           CKP_RESET     = 1'b1;

  ////////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_LOW  = 3'b010,
    ST_TX   = 3'b011,
    ST_RX   = 3'b100
  } isx_state_t;

  typedef struct packed {
    logic [7:0] data;
    logic       load_buf;
    logic       clear_ckp;
    logic       set_ua;
    logic       read_dir;
    logic       is_data;
    logic       ack_phase;
  } isx_event_t;

  typedef struct packed {
    logic ten_bit;
    logic addr_hold;
    logic data_hold;
    logic stretch;
    logic coll_detect;
  } isx_cfg_t;

endpackage

// ### logic/isx_sync.sv
// Two-flop level synchroniser, parameterised width
module isx_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      meta_reg <= '0;
      q_out    <= '0;
    end else begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end

endmodule

// ### logic/isx_slave.sv
// Two-wire bus slave: read-address transmitter and 10-bit addressed receiver
module isx_slave (
  input  wire logic       CLK_IN,
  input  wire logic       RESET_IN,
  input  wire logic       SCL_CLK_IN,
  input  wire logic       SDA_IN,
  output logic            SCL_OUT,
  output logic            SCL_OE_N_OUT,
  output logic            SDA_OUT,
  output logic            SDA_OE_N_OUT,
  input  wire logic       TEN_BIT_IN,
  input  wire logic       ADDR_HOLD_EN_IN,
  input  wire logic       DATA_HOLD_EN_IN,
  input  wire logic       STRETCH_EN_IN,
  input  wire logic       COLL_DETECT_EN_IN,
  input  wire logic       ACK_VALUE_IN,
  input  wire logic       BUF_WRITE_IN,
  input  wire logic [7:0] BUF_WDATA_IN,
  input  wire logic       BUF_READ_IN,
  input  wire logic       ADDR_WRITE_IN,
  input  wire logic [7:0] ADDR_WDATA_IN,
  input  wire logic       CLK_RELEASE_SET_IN,
  input  wire logic       EVENT_CLEAR_IN,
  input  wire logic       COLL_CLEAR_IN,
  output logic [7:0]      BUF_RDATA_OUT,
  output logic [7:0]      OWN_ADDR_OUT,
  output logic            EVENT_FLAG_OUT,
  output logic            COLL_FLAG_OUT,
  output logic            BUF_FULL_OUT,
  output logic            DIR_READ_OUT,
  output logic            DATA_NOT_ADDR_OUT,
  output logic            ACK_PHASE_OUT,
  output logic            ADDR_UPDATE_OUT,
  output logic            MASTER_ACK_OUT,
  output logic            CLK_RELEASE_OUT
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  isx_pkg::isx_state_t state_reg;
  isx_pkg::isx_event_t ev_reg;
  isx_pkg::isx_cfg_t   cfg_raw;
  isx_pkg::isx_cfg_t   cfg_s;
  logic [3:0]          cnt_reg;
  logic [7:0]          rx_sh_reg;
  logic [7:0]          byte_reg;
  logic [7:0]          shift_register_reg;
  logic [7:0]          transfer_buffer_reg;
  logic [7:0]          own_address_reg;
  logic                start_tog_reg;
  logic                start_tog_s;
  logic                start_seen_reg;
  logic                coll_tog_reg;
  logic                coll_seen_reg;
  logic                ack_rx_reg;
  logic                mack_reg;
  logic                ack_drive_reg;
  logic                ack_sw_reg;
  logic                match_reg;
  logic                rd_reg;
  logic                ten_done_reg;
  logic                hold_tog_reg;
  logic                ev_tog_reg;
  logic [3:0]          link_raw;
  logic [3:0]          link_s;
  logic                ev_s;
  logic                hold_s;
  logic                coll_s;
  logic                mack_s;
  logic                ev_seen_reg;
  logic                coll_seen_sys_reg;
  logic                rel_tog_reg;
  logic                ev_new;
  logic                hit7;
  logic                hit_hi;
  logic                hit_lo;
  logic                byte_hit;
  logic                byte_hold;
  logic                byte_rd;
  logic [3:0]          tx_diff;
  logic [2:0]          tx_idx;
  logic                tx_active;
  logic                tx_low;
  logic                ack_low;

  function automatic isx_pkg::isx_event_t mk_event(
    input logic [7:0] data,
    input logic       load_buf,
    input logic       clear_ckp,
    input logic       set_ua,
    input logic       read_dir,
    input logic       is_data,
    input logic       ack_phase
  );
    isx_pkg::isx_event_t ev;
    ev.data      = data;
    ev.load_buf  = load_buf;
    ev.clear_ckp = clear_ckp;
    ev.set_ua    = set_ua;
    ev.read_dir  = read_dir;
    ev.is_data   = is_data;
    ev.ack_phase = ack_phase;
    return ev;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Start detection: data falling while clock high
  always_ff @(negedge SDA_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      start_tog_reg <= 1'b0;
    end else if (SCL_CLK_IN) begin
      start_tog_reg <= ~start_tog_reg;
    end
  end

  isx_sync #(.WIDTH(1)) u_start_sync (
    .clk_in   (SCL_CLK_IN),
    .reset_in (RESET_IN),
    .d_in     (start_tog_reg),
    .q_out    (start_tog_s)
  );

  assign cfg_raw = '{ten_bit:     TEN_BIT_IN,
                     addr_hold:   ADDR_HOLD_EN_IN,
                     data_hold:   DATA_HOLD_EN_IN,
                     stretch:     STRETCH_EN_IN,
                     coll_detect: COLL_DETECT_EN_IN};

  isx_sync #(.WIDTH(isx_pkg::CFG_W)) u_cfg_sync (
    .clk_in   (SCL_CLK_IN),
    .reset_in (RESET_IN),
    .d_in     (cfg_raw),
    .q_out    (cfg_s)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Address compare
  assign hit7   = ~cfg_s.ten_bit &&
                  (rx_sh_reg[7:1] == own_address_reg[7:1]);
  assign hit_hi = cfg_s.ten_bit &&
                  (rx_sh_reg[7:isx_pkg::TEN_MARK_LSB] == isx_pkg::TEN_HIGH_MARK) &&
                  (rx_sh_reg[isx_pkg::TEN_HI_MSB:isx_pkg::TEN_HI_LSB] ==
                   own_address_reg[isx_pkg::TEN_HI_MSB:isx_pkg::TEN_HI_LSB]) &&
                  (~rx_sh_reg[isx_pkg::ADDR_RW_BIT] || ten_done_reg);
  assign hit_lo = (rx_sh_reg == own_address_reg);

  always_comb begin
    byte_hit  = 1'b0;
    byte_hold = cfg_s.addr_hold;
    byte_rd   = rd_reg;
    unique case (state_reg)
      isx_pkg::ST_ADDR: begin
        byte_hit = hit7 | hit_hi;
        byte_rd  = rx_sh_reg[isx_pkg::ADDR_RW_BIT];
      end
      isx_pkg::ST_LOW: begin
        byte_hit = hit_lo;
      end
      isx_pkg::ST_RX: begin
        byte_hit  = 1'b1;
        byte_hold = cfg_s.data_hold;
      end
      isx_pkg::ST_TX,
      isx_pkg::ST_IDLE: begin
        byte_hit = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Link engine on falling clock edges
  always_ff @(negedge SCL_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      state_reg      <= isx_pkg::ST_IDLE;
      cnt_reg        <= isx_pkg::CNT_ZERO;
      start_seen_reg <= 1'b0;
      coll_seen_reg  <= 1'b0;
      ack_drive_reg  <= 1'b0;
      ack_sw_reg     <= 1'b0;
      match_reg      <= 1'b0;
      rd_reg         <= 1'b0;
      ten_done_reg   <= 1'b0;
      byte_reg       <= isx_pkg::BYTE_RESET;
      hold_tog_reg   <= 1'b0;
      ev_tog_reg     <= 1'b0;
      ev_reg         <= '0;
    end else if (start_tog_s != start_seen_reg) begin
      // Start seen two edges late; two bits already shifted in
      start_seen_reg <= start_tog_s;
      state_reg      <= isx_pkg::ST_ADDR;
      cnt_reg        <= isx_pkg::CNT_START;
      ack_drive_reg  <= 1'b0;
      ack_sw_reg     <= 1'b0;
    end else if (coll_tog_reg != coll_seen_reg) begin
      coll_seen_reg <= coll_tog_reg;
      state_reg     <= isx_pkg::ST_IDLE;
      ack_drive_reg <= 1'b0;
    end else if (state_reg != isx_pkg::ST_IDLE) begin
      cnt_reg <= (cnt_reg == isx_pkg::CNT_NINTH) ? isx_pkg::CNT_ZERO :
                 cnt_reg + isx_pkg::CNT_ONE;
      if (cnt_reg == isx_pkg::CNT_EIGHTH) begin
        byte_reg   <= rx_sh_reg;
        ack_sw_reg <= 1'b0;
        if (byte_hit) begin
          match_reg     <= 1'b1;
          ack_drive_reg <= 1'b1;
          rd_reg        <= byte_rd;
          if (byte_hold) begin
            ack_sw_reg   <= 1'b1;
            hold_tog_reg <= ~hold_tog_reg;
            ev_tog_reg   <= ~ev_tog_reg;
            ev_reg       <= mk_event(rx_sh_reg, 1'b1, 1'b1, 1'b0, byte_rd,
                                     state_reg == isx_pkg::ST_RX, 1'b1);
          end
        end else begin
          match_reg     <= 1'b0;
          ack_drive_reg <= 1'b0;
          if (state_reg == isx_pkg::ST_ADDR) begin
            state_reg    <= isx_pkg::ST_IDLE;
            ten_done_reg <= 1'b0;
          end
        end
      end else if (cnt_reg == isx_pkg::CNT_NINTH) begin
        ack_drive_reg <= 1'b0;
        unique case (state_reg)
          isx_pkg::ST_ADDR: begin
            if (ack_rx_reg) begin
              state_reg <= isx_pkg::ST_IDLE;
            end else if (rd_reg) begin
              state_reg    <= isx_pkg::ST_TX;
              hold_tog_reg <= ~hold_tog_reg;
              ev_tog_reg   <= ~ev_tog_reg;
              ev_reg       <= mk_event(byte_reg, ~ack_sw_reg, 1'b1, 1'b0,
                                       1'b1, 1'b0, 1'b0);
            end else if (cfg_s.ten_bit) begin
              state_reg    <= isx_pkg::ST_LOW;
              hold_tog_reg <= ~hold_tog_reg;
              ev_tog_reg   <= ~ev_tog_reg;
              ev_reg       <= mk_event(byte_reg, ~ack_sw_reg, 1'b0, 1'b1,
                                       1'b0, 1'b0, 1'b0);
            end else begin
              state_reg  <= isx_pkg::ST_RX;
              ev_tog_reg <= ~ev_tog_reg;
              ev_reg     <= mk_event(byte_reg, ~ack_sw_reg, cfg_s.stretch, 1'b0,
                                     1'b0, 1'b0, 1'b0);
              if (cfg_s.stretch) begin
                hold_tog_reg <= ~hold_tog_reg;
              end
            end
          end
          isx_pkg::ST_LOW: begin
            // Mismatch still flags and holds, but loads nothing
            hold_tog_reg <= ~hold_tog_reg;
            ev_tog_reg   <= ~ev_tog_reg;
            ev_reg       <= mk_event(byte_reg, match_reg & ~ack_sw_reg, 1'b0, 1'b1,
                                     1'b0, 1'b0, 1'b0);
            if (match_reg && !ack_rx_reg) begin
              ten_done_reg <= 1'b1;
              state_reg    <= isx_pkg::ST_RX;
            end else begin
              state_reg <= isx_pkg::ST_IDLE;
            end
          end
          isx_pkg::ST_RX: begin
            if (ack_rx_reg) begin
              state_reg <= isx_pkg::ST_IDLE;
            end else begin
              ev_tog_reg <= ~ev_tog_reg;
              ev_reg     <= mk_event(byte_reg, ~ack_sw_reg, cfg_s.stretch, 1'b0,
                                     1'b0, 1'b1, 1'b0);
              if (cfg_s.stretch) begin
                hold_tog_reg <= ~hold_tog_reg;
              end
            end
          end
          isx_pkg::ST_TX: begin
            ev_tog_reg <= ~ev_tog_reg;
            ev_reg     <= mk_event(isx_pkg::BYTE_RESET, 1'b0, ~ack_rx_reg, 1'b0,
                                   1'b1, 1'b1, 1'b0);
            if (ack_rx_reg) begin
              state_reg <= isx_pkg::ST_IDLE;
            end else begin
              hold_tog_reg <= ~hold_tog_reg;
            end
          end
          isx_pkg::ST_IDLE: begin
            state_reg <= isx_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Link sampling on rising clock edges
  always_ff @(posedge SCL_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      rx_sh_reg <= isx_pkg::BYTE_RESET;
    end else begin
      rx_sh_reg <= {rx_sh_reg[6:0], SDA_IN};
    end
  end

  always_ff @(posedge SCL_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      ack_rx_reg <= 1'b1;
      mack_reg   <= 1'b0;
    end else if (cnt_reg == isx_pkg::CNT_NINTH) begin
      ack_rx_reg <= SDA_IN;
      if (state_reg == isx_pkg::ST_TX) begin
        mack_reg <= SDA_IN;
      end
    end
  end

  always_ff @(posedge SCL_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      coll_tog_reg <= 1'b0;
    end else if (cfg_s.coll_detect && tx_active &&
                 shift_register_reg[tx_idx] && !SDA_IN) begin
      coll_tog_reg <= ~coll_tog_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin drive, open drain only
  assign tx_diff   = isx_pkg::CNT_EIGHTH - cnt_reg;
  assign tx_idx    = tx_diff[2:0];
  assign tx_active = (state_reg == isx_pkg::ST_TX) && (cnt_reg <= isx_pkg::CNT_EIGHTH);
  // Shift register is held steady by software while the byte is on the wire
  assign tx_low    = tx_active && !shift_register_reg[tx_idx];
  assign ack_low   = ack_drive_reg && !(ack_sw_reg && ACK_VALUE_IN);
  assign SDA_OUT   = 1'b0;
  assign SCL_OUT   = 1'b0;
  assign SDA_OE_N_OUT = ~(tx_low | ack_low);
  // Held while a stretch toggle is not yet matched by a release toggle
  assign SCL_OE_N_OUT = ~(hold_tog_reg ^ rel_tog_reg);

  ////////////////////////////////////////////////////////////////////////////////
  // Crossing into the system domain
  assign link_raw = {ev_tog_reg, hold_tog_reg, coll_tog_reg, mack_reg};

  isx_sync #(.WIDTH(isx_pkg::LINK_SYNC_W)) u_link_sync (
    .clk_in   (CLK_IN),
    .reset_in (RESET_IN),
    .d_in     (link_raw),
    .q_out    (link_s)
  );

  assign ev_s   = link_s[3];
  assign hold_s = link_s[2];
  assign coll_s = link_s[1];
  assign mack_s = link_s[0];
  assign ev_new = (ev_s != ev_seen_reg);

  ////////////////////////////////////////////////////////////////////////////////
  // Software-facing state
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      ev_seen_reg       <= 1'b0;
      EVENT_FLAG_OUT    <= 1'b0;
      DIR_READ_OUT      <= 1'b0;
      DATA_NOT_ADDR_OUT <= 1'b0;
      ACK_PHASE_OUT     <= 1'b0;
    end else begin
      ev_seen_reg <= ev_s;
      if (ev_new) begin
        EVENT_FLAG_OUT    <= 1'b1;
        DIR_READ_OUT      <= ev_reg.read_dir;
        DATA_NOT_ADDR_OUT <= ev_reg.is_data;
        ACK_PHASE_OUT     <= ev_reg.ack_phase;
      end else if (EVENT_CLEAR_IN) begin
        EVENT_FLAG_OUT <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      transfer_buffer_reg <= isx_pkg::BYTE_RESET;
      shift_register_reg  <= isx_pkg::BYTE_RESET;
      BUF_FULL_OUT        <= 1'b0;
    end else begin
      if (BUF_WRITE_IN) begin
        transfer_buffer_reg <= BUF_WDATA_IN;
        shift_register_reg  <= BUF_WDATA_IN;
      end else if (ev_new && ev_reg.load_buf) begin
        transfer_buffer_reg <= ev_reg.data;
      end
      if (BUF_WRITE_IN || (ev_new && ev_reg.load_buf)) begin
        BUF_FULL_OUT <= 1'b1;
      end else if (BUF_READ_IN) begin
        BUF_FULL_OUT <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      own_address_reg <= isx_pkg::ADDR_RESET;
      ADDR_UPDATE_OUT <= 1'b0;
    end else begin
      if (ADDR_WRITE_IN) begin
        own_address_reg <= ADDR_WDATA_IN;
      end
      if (ev_new && ev_reg.set_ua) begin
        ADDR_UPDATE_OUT <= 1'b1;
      end else if (ADDR_WRITE_IN) begin
        ADDR_UPDATE_OUT <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      CLK_RELEASE_OUT <= isx_pkg::CKP_RESET;
    end else if (ev_new && ev_reg.clear_ckp) begin
      CLK_RELEASE_OUT <= 1'b0;
    end else if (CLK_RELEASE_SET_IN) begin
      CLK_RELEASE_OUT <= 1'b1;
    end
  end

  // Release only after the pending event has been taken in
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      rel_tog_reg <= 1'b0;
    end else if ((hold_s != rel_tog_reg) && !ev_new &&
                 CLK_RELEASE_OUT && !ADDR_UPDATE_OUT) begin
      rel_tog_reg <= hold_s;
    end
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      coll_seen_sys_reg <= 1'b0;
      COLL_FLAG_OUT     <= 1'b0;
      MASTER_ACK_OUT    <= 1'b0;
    end else begin
      coll_seen_sys_reg <= coll_s;
      MASTER_ACK_OUT    <= mack_s;
      if (coll_s != coll_seen_sys_reg) begin
        COLL_FLAG_OUT <= 1'b1;
      end else if (COLL_CLEAR_IN) begin
        COLL_FLAG_OUT <= 1'b0;
      end
    end
  end

  assign BUF_RDATA_OUT = transfer_buffer_reg;
  assign OWN_ADDR_OUT  = own_address_reg;

endmodule

// ### tb/isx_slave_chk.sv
// Port checker for the two-wire slave
module isx_slave_chk (
  input logic       CLK_IN,
  input logic       RESET_IN,
  input logic       SCL_OUT,
  input logic       SDA_OUT,
  input logic       SCL_OE_N_OUT,
  input logic       SDA_OE_N_OUT,
  input logic       BUF_WRITE_IN,
  input logic [7:0] BUF_WDATA_IN,
  input logic       ADDR_WRITE_IN,
  input logic [7:0] ADDR_WDATA_IN,
  input logic       CLK_RELEASE_SET_IN,
  input logic       EVENT_CLEAR_IN,
  input logic [7:0] BUF_RDATA_OUT,
  input logic [7:0] OWN_ADDR_OUT,
  input logic       EVENT_FLAG_OUT,
  input logic       BUF_FULL_OUT,
  input logic       ADDR_UPDATE_OUT,
  input logic       CLK_RELEASE_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);
  sequence s_own_load;
    ##1 OWN_ADDR_OUT == $past(ADDR_WDATA_IN) && !ADDR_UPDATE_OUT;
  endsequence
  chk_scl_low_only: assert property (SCL_OUT == 1'b0) else $error("scl not low");
  chk_sda_low_only: assert property (SDA_OUT == 1'b0) else $error("sda not low");
  chk_buf_load: assert property (
    BUF_WRITE_IN |=> BUF_FULL_OUT && BUF_RDATA_OUT == $past(BUF_WDATA_IN)) else $error("no load");
  chk_own_load: assert property (ADDR_WRITE_IN |-> s_own_load) else $error("no addr");
  chk_release_rise: assert property (
    $rose(CLK_RELEASE_OUT) |-> $past(CLK_RELEASE_SET_IN)) else $error("stray release");
  chk_event_fall: assert property (
    $fell(EVENT_FLAG_OUT) |-> $past(EVENT_CLEAR_IN)) else $error("event lost");
  chk_update_hold: assert property (
    ADDR_UPDATE_OUT |-> !SCL_OE_N_OUT) else $error("clock not held");
  chk_reset_idle: assert property ($fell(RESET_IN) |-> CLK_RELEASE_OUT && SCL_OE_N_OUT
    && SDA_OE_N_OUT && !EVENT_FLAG_OUT) else $error("not idle");
endmodule
bind isx_slave isx_slave_chk i_chk (.*);

// ### tb/isx_master_model.sv
// Bit-level bus master on the open-drain clock and data lines
module isx_master_model (
  input  logic scl_bus,
  input  logic sda_bus,
  output logic scl_drv,
  output logic sda_drv
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end
  // Also serves as repeated start
  task automatic start_cond();
    sda_drv = 1'b1;
    #40 scl_drv = 1'b1;
    #40 sda_drv = 1'b0;
    #40 scl_drv = 1'b0;
    #40;
  endtask
  task automatic stop_cond();
    sda_drv = 1'b0;
    #40 scl_drv = 1'b1;
    #40 sda_drv = 1'b1;
  endtask
  // Nine pulses, MSB first; the ninth slot carries ack_in
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                      output logic ack_out);
    logic [8:0] r;
    for (int i = 8; i >= 0; i--) begin
      sda_drv = i ? d[i-1] : ack_in;
      #40 scl_drv = 1'b1;
      for (int w = 0; w < 200 && scl_bus !== 1'b1; w++) #10;
      #40 r[i] = sda_bus;
      #40 scl_drv = 1'b0;
      #40;
    end
    q = r[8:1];
    ack_out = r[0];
  endtask
endmodule

// ### tb/isx_slave_tb.sv
// Bench: 10-bit write, restart and two-byte read, then 7-bit held read with collision
module isx_slave_tb;
  timeunit 1ns;
  timeprecision 1ns;
  isx_pkg::isx_cfg_t cfg;
  logic clk = 1'b0, rst = 1'b0, bw_en, rd_en, aw_en, rel_set, ev_clr, ack_v, a, coll_clr;
  logic [7:0] bw, aw, q, rdata, own;
  logic scl_drv, sda_drv, scl_oe_n, sda_oe_n, ev, full, dir, dna, ua, mack, rel, coll, ackp;
  int miscompares = 0, tests_run = 0, cyc = 0;
  wire scl = scl_drv & scl_oe_n;
  wire sda = sda_drv & sda_oe_n;
  isx_master_model i_mst (.scl_bus(scl), .sda_bus(sda), .scl_drv(scl_drv), .sda_drv(sda_drv));
  isx_slave i_dut (.CLK_IN(clk), .RESET_IN(rst), .SCL_CLK_IN(scl), .SDA_IN(sda), .SCL_OUT(),
    .SCL_OE_N_OUT(scl_oe_n), .SDA_OUT(), .SDA_OE_N_OUT(sda_oe_n), .TEN_BIT_IN(cfg.ten_bit),
    .ADDR_HOLD_EN_IN(cfg.addr_hold), .DATA_HOLD_EN_IN(cfg.data_hold),
    .STRETCH_EN_IN(cfg.stretch), .COLL_DETECT_EN_IN(cfg.coll_detect), .ACK_VALUE_IN(ack_v),
    .BUF_WRITE_IN(bw_en), .BUF_WDATA_IN(bw), .BUF_READ_IN(rd_en), .ADDR_WRITE_IN(aw_en),
    .ADDR_WDATA_IN(aw), .CLK_RELEASE_SET_IN(rel_set), .EVENT_CLEAR_IN(ev_clr),
    .COLL_CLEAR_IN(coll_clr), .BUF_RDATA_OUT(rdata), .OWN_ADDR_OUT(own), .EVENT_FLAG_OUT(ev),
    .COLL_FLAG_OUT(coll), .BUF_FULL_OUT(full), .DIR_READ_OUT(dir), .DATA_NOT_ADDR_OUT(dna),
    .ACK_PHASE_OUT(ackp), .ADDR_UPDATE_OUT(ua), .MASTER_ACK_OUT(mack), .CLK_RELEASE_OUT(rel));
  initial forever #50 clk = ~clk;
  task automatic chk(string n, logic [7:0] seen, logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic pls(ref logic s);
    @(negedge clk) s = 1'b1;
    @(negedge clk) s = 1'b0;
  endtask
  task automatic wait_event();
    for (int n = 0; n < 60 && ev !== 1'b1; n++) @(negedge clk);
    chk("event", 8'(ev), 8'h01);
  endtask
  task automatic t_ten_write();
    i_mst.start_cond();
    i_mst.xfer(8'hf4, 1'b1, q, a);
    chk("high ack", 8'(a), 8'h00);
    wait_event();
    chk("update", 8'(ua), 8'h01);
    pls(ev_clr);
    aw = 8'ha5;
    pls(aw_en);
    i_mst.xfer(8'ha5, 1'b1, q, a);
    chk("low ack", 8'(a), 8'h00);
    wait_event();
    chk("low buf", rdata, 8'ha5);
    pls(ev_clr);
    pls(rd_en);
    aw = 8'hf4;
    pls(aw_en);
    i_mst.xfer(8'h3c, 1'b1, q, a);
    wait_event();
    chk("data", rdata, 8'h3c);
    chk("rx release", 8'(rel), 8'h00);
    chk("rx hold", 8'(scl_oe_n), 8'h00);
    pls(ev_clr);
    pls(rd_en);
    chk("full", 8'(full), 8'h00);
    pls(rel_set);
    $display("ten-bit write test done");
  endtask
  task automatic t_ten_read();
    i_mst.start_cond();
    i_mst.xfer(8'hf5, 1'b1, q, a);
    wait_event();
    chk("read ack", 8'(a), 8'h00);
    chk("dir", 8'(dir), 8'h01);
    chk("addr buf", rdata, 8'hf5);
    chk("rd release", 8'(rel), 8'h00);
    pls(ev_clr);
    pls(rd_en);
    for (int k = 0; k < 2; k++) begin
      bw = k ? 8'h5a : 8'hc3;
      pls(bw_en);
      chk("tx full", 8'(full), 8'h01);
      pls(rel_set);
      i_mst.xfer(8'hff, k[0], q, a);
      chk("tx byte", q, bw);
      wait_event();
      chk("data flag", 8'(dna), 8'h01);
      chk("master ack", 8'(mack), 8'(k));
      chk("tx hold", 8'(scl_oe_n), 8'(k));
      pls(ev_clr);
    end
    i_mst.stop_cond();
    $display("ten-bit read test done");
  endtask
  task automatic t_seven_hold_read();
    @(negedge clk);
    cfg = '{ten_bit: 1'b0, addr_hold: 1'b1, data_hold: 1'b0, stretch: 1'b0, coll_detect: 1'b1};
    ack_v = 1'b1;
    aw = 8'h52;
    pls(aw_en);
    chk("own7", own, 8'h52);
    i_mst.start_cond();
    fork
      i_mst.xfer(8'h53, 1'b1, q, a);
      begin
        wait_event();
        chk("hold phase", 8'(ackp), 8'h01);
        chk("hold dir", 8'(dir), 8'h01);
        chk("hold buf", rdata, 8'h53);
        chk("hold release", 8'(rel), 8'h00);
        chk("hold scl", 8'(scl_oe_n), 8'h00);
        chk("hold nack", 8'(sda_oe_n), 8'h01);
        pls(ev_clr);
        ack_v = 1'b0;
        pls(rel_set);
      end
    join
    chk("hold ack", 8'(a), 8'h00);
    wait_event();
    chk("late phase", 8'(ackp), 8'h00);
    chk("auto release", 8'(rel), 8'h00);
    pls(ev_clr);
    bw = 8'h80;
    pls(bw_en);
    pls(rel_set);
    i_mst.xfer(8'h00, 1'b1, q, a);
    chk("collision", 8'(coll), 8'h01);
    chk("coll idle", 8'(scl_oe_n), 8'h01);
    pls(coll_clr);
    chk("coll clear", 8'(coll), 8'h00);
    i_mst.stop_cond();
    $display("seven-bit hold read test done");
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  initial begin
    cfg = '{ten_bit: 1'b1, addr_hold: 1'b0, data_hold: 1'b0, stretch: 1'b1, coll_detect: 1'b1};
    {bw_en, rd_en, aw_en, rel_set, ev_clr, ack_v, coll_clr, bw, aw} = '0;
    #1 rst = 1'b1;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    aw = 8'hf4;
    pls(aw_en);
    chk("own", own, 8'hf4);
    t_ten_write();
    t_ten_read();
    t_seven_hold_read();
    report_and_stop();
  end
endmodule
